// ===== logic/vtx_defines.vh
// register map, field positions, opcodes and symbol timing of the vpw transmit sequencer
`ifndef VTX_DEFINES_VH
`define VTX_DEFINES_VH

// register byte offsets on apb
`define VTX_OFS_OPCODE    8'h00
`define VTX_OFS_TXBYTE    8'h04
`define VTX_OFS_PADDR     8'h08
`define VTX_OFS_CTRL      8'h0c
`define VTX_OFS_STATUS    8'h10

// reset values
`define VTX_RST_OPCODE    8'h00
`define VTX_RST_BYTE      8'h00
`define VTX_RST_CRC       8'hff

// transmit opcode register fields
`define VTX_LEN_HI        7
`define VTX_LEN_LO        4
`define VTX_OP_HI         2
`define VTX_OP_LO         0

// control register field
`define VTX_CTRL_LIMOFF   0

// status register fields
`define VTX_ST_READY      0
`define VTX_ST_ABORT      1
`define VTX_ST_UNDER      2
`define VTX_ST_LOCKED     3
`define VTX_ST_BUSY       4

// opcode codes
`define VTX_OP_CANCEL     3'h0
`define VTX_OP_BREAK      3'h1
`define VTX_OP_MSG        3'h2
`define VTX_OP_MSGC       3'h3
`define VTX_OP_R1         3'h4
`define VTX_OP_R2         3'h5
`define VTX_OP_R3         3'h6
`define VTX_OP_R3C        3'h7

// frame length figures
`define VTX_LEN_MAXOK     4'hb
`define VTX_CNT_MSG_LAST  4'ha
`define VTX_CNT_RESP_MAX  4'hb

// crc-8 polynomial
`define VTX_CRC_POLY      8'h1d

// symbol times in microseconds and clock rate in mhz
`define VTX_CLK_MHZ       40
`define VTX_T_SHORT_US    64
`define VTX_T_LONG_US     128
`define VTX_T_SOF_US      200
`define VTX_T_EOD_US      200
`define VTX_T_BRK_US      300

`endif

// ===== logic/vtx_opseq.v
// vpw transmit opcode sequencer with apb register slave
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "vtx_defines.vh"

// What this block does
// - opcode write starts a byte transmit attempt
// - message/type3 load data byte, crc variants append
// - type1/type2 responses load physical address
// - invalid opcode: no attempt, set aborted flag
// - opcode writes accepted anytime except during break, replacing queued one
// - response needs received count equal length field
// - limit on: length 12..15 aborts
// - limit off: length 1..15 valid
// - message opcodes ignore length field
// - length zero skips check, needs clean frame
// - opcode bits 2:0 decode eight actions
// - idle bus: start-of-frame then data byte
// - busy bus: chain byte after previous one
// - message over type3: abort, underflow, bad crc
// - limit on, count ten message: underflow
// - limit on, message-crc needs count at most ten
// - after underflow next message starts new frame
// - message-crc: data, crc, then passive end
// - type1 response needs crc, length, end, count
// - response refused while busy or receiving response, except type3 while type3 executes
// - accepted byte opcode write clears ready, load sets it
// - cancel sets ready and drops queued opcode
// - break sent at once, cancel cannot stop it
module vtx_opseq #(
	parameter [13:0] SHORT_CYC = `VTX_T_SHORT_US * `VTX_CLK_MHZ,
	parameter [13:0] LONG_CYC  = `VTX_T_LONG_US * `VTX_CLK_MHZ,
	parameter [13:0] SOF_CYC   = `VTX_T_SOF_US * `VTX_CLK_MHZ,
	parameter [13:0] EOD_CYC   = `VTX_T_EOD_US * `VTX_CLK_MHZ,
	parameter [13:0] BRK_CYC   = `VTX_T_BRK_US * `VTX_CLK_MHZ
) (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// receiver status
	input  wire        bus_idle,
	input  wire        eod_seen,
	input  wire        arb_lost,
	input  wire [3:0]  rx_byte_count,
	input  wire        rx_in_response,
	input  wire        crc_ok,
	input  wire        frame_sync_error,
	input  wire        bit_decode_error,
	input  wire        received_break_flag,
	// encoded bus output, high means active
	output reg         encoded_bus_output
);

	// ******************************************
	// states and decode
	// ******************************************
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_SOF  = 6'h02;
	localparam [5:0] S_BIT  = 6'h04;
	localparam [5:0] S_WAIT = 6'h08;
	localparam [5:0] S_EOD  = 6'h10;
	localparam [5:0] S_BRK  = 6'h20;

	reg  [5:0]  state_reg;
	reg  [7:0]  opcode_reg;
	reg  [7:0]  tx_byte_holding;
	reg  [7:0]  phys_addr_reg;
	reg         frame_limit_off;
	reg         tx_ready_flag;
	reg         request_aborted_flag;
	reg         tx_underflow_flag;
	reg         locked_reg;
	reg         pend_reg;
	reg  [2:0]  pend_op_reg;
	reg  [3:0]  pend_len_reg;
	reg  [2:0]  op_reg;
	reg         crc_after_reg;
	reg         bad_crc_reg;
	reg         in_crc_reg;
	reg  [7:0]  shift_reg;
	reg  [2:0]  bit_cnt_reg;
	reg  [13:0] timer_reg;
	reg         level_reg;
	reg  [7:0]  crc_reg;

	wire        wr_en  = psel & penable & pwrite;
	wire        rd_set = psel & ~penable & ~pwrite;
	wire        mapped = (paddr == `VTX_OFS_OPCODE) | (paddr == `VTX_OFS_TXBYTE) |
	                     (paddr == `VTX_OFS_PADDR) | (paddr == `VTX_OFS_CTRL) |
	                     (paddr == `VTX_OFS_STATUS);
	wire        wr_op  = wr_en & (paddr == `VTX_OFS_OPCODE);
	wire [2:0]  opcode_select    = pwdata[`VTX_OP_HI:`VTX_OP_LO];
	wire [3:0]  msg_length_count = pwdata[`VTX_LEN_HI:`VTX_LEN_LO];

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// opcode classes of the queued and the executing byte
	wire new_msg  = (opcode_select == `VTX_OP_MSG) | (opcode_select == `VTX_OP_MSGC);
	wire new_resp = opcode_select[2];
	wire busy     = (state_reg == S_SOF) | (state_reg == S_BIT);
	wire exec_msg = busy & ((op_reg == `VTX_OP_MSG) | (op_reg == `VTX_OP_MSGC));
	wire exec_r3  = busy & (op_reg == `VTX_OP_R3);
	wire exec_fin = busy & ((op_reg == `VTX_OP_R1) | (op_reg == `VTX_OP_R2) |
	                (op_reg == `VTX_OP_R3C));
	wire pend_msg = (pend_op_reg == `VTX_OP_MSG) | (pend_op_reg == `VTX_OP_MSGC);
	wire tdone    = (timer_reg == 14'h0001);

	// ******************************************
	// opcode write screening
	// ******************************************
	reg wr_abort;
	reg wr_under;
	// decide refusal at the write so the aborted flag and ready rise at once
	always @*
	begin
		wr_abort = 1'b0;
		wr_under = 1'b0;
		if (new_msg)
		begin
			// length field is not looked at here
			if (exec_r3)
			begin
				wr_abort = 1'b1;
				wr_under = 1'b1;
			end
			else if (~frame_limit_off & (opcode_select == `VTX_OP_MSG) &
			         (rx_byte_count == `VTX_CNT_MSG_LAST))
			begin
				wr_abort = 1'b1;
				wr_under = 1'b1;
			end
			else if (~frame_limit_off & (opcode_select == `VTX_OP_MSGC) &
			         (rx_byte_count > `VTX_CNT_MSG_LAST))
			begin
				wr_abort = 1'b1;
				wr_under = 1'b1;
			end
		end
		else if (new_resp)
		begin
			if (~frame_limit_off & (msg_length_count > `VTX_LEN_MAXOK))
				wr_abort = 1'b1;
			else if (exec_msg | (exec_r3 & ~opcode_select[1]))
			begin
				wr_abort = 1'b1;
				wr_under = 1'b1;
			end
			else if (exec_fin | (rx_in_response & ~exec_r3))
				wr_abort = 1'b1;
		end
	end

	// ******************************************
	// frame helpers
	// ******************************************
	// response gate evaluated when the end-of-data symbol arrives
	wire len_ok  = (pend_len_reg == 4'h0) | (pend_len_reg == rx_byte_count);
	wire clean   = crc_ok & ~frame_sync_error & ~bit_decode_error & ~received_break_flag;
	wire cnt_ok  = frame_limit_off | (rx_byte_count <= `VTX_CNT_RESP_MAX);
	wire resp_ok = len_ok & clean & cnt_ok;

	wire last_bit = (bit_cnt_reg == 3'h0);
	wire byte_end = (state_reg == S_BIT) & tdone & last_bit;
	wire chain_ok = ((op_reg == `VTX_OP_MSG) & pend_msg) |
	                ((op_reg == `VTX_OP_R3) & pend_op_reg[2] & pend_op_reg[1]);
	wire non_fin  = (op_reg == `VTX_OP_MSG) | (op_reg == `VTX_OP_R3);

	// moment when the queued byte enters the shifter
	wire go_byte = pend_reg & (
		((state_reg == S_IDLE) & pend_msg & ~locked_reg & ~bus_idle) |
		((state_reg == S_SOF) & tdone) |
		((state_reg == S_WAIT) & eod_seen & resp_ok) |
		(byte_end & ~crc_after_reg & ~bad_crc_reg & ~in_crc_reg & chain_ok));

	// type1/type2 take the physical address, others the data byte
	wire [7:0] byte_src = (pend_op_reg[2] & ~pend_op_reg[1]) ? phys_addr_reg : tx_byte_holding;

	// crc-8 step for the bit now ending; crc bytes themselves are not folded in
	wire       fb      = crc_reg[7] ^ shift_reg[7];
	wire [7:0] crc_upd = in_crc_reg ? crc_reg :
	                     ({crc_reg[6:0], 1'b0} ^ (fb ? `VTX_CRC_POLY : 8'h00));

	// vpw: a bit is long when its value differs from the level it is driven at
	wire [13:0] dur_next = (shift_reg[6] ^ ~level_reg) ? LONG_CYC : SHORT_CYC;
	// a chained byte opens on the level opposite to the bit just ended
	wire        first_lvl = byte_end ? ~level_reg : level_reg;

	// ******************************************
	// register writes and flags
	// ******************************************
	// flags: every set event wins over a software clear in the same cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			opcode_reg           <= `VTX_RST_OPCODE;
			tx_byte_holding      <= `VTX_RST_BYTE;
			phys_addr_reg        <= `VTX_RST_BYTE;
			frame_limit_off      <= 1'b0;
			tx_ready_flag        <= 1'b1;
			request_aborted_flag <= 1'b0;
			tx_underflow_flag    <= 1'b0;
		end
		else
		begin
			if (wr_op)
				opcode_reg <= {msg_length_count, 1'b0, opcode_select};
			if (wr_en & (paddr == `VTX_OFS_TXBYTE))
				tx_byte_holding <= pwdata[7:0];
			if (wr_en & (paddr == `VTX_OFS_PADDR))
				phys_addr_reg <= pwdata[7:0];
			if (wr_en & (paddr == `VTX_OFS_CTRL))
				frame_limit_off <= pwdata[`VTX_CTRL_LIMOFF];
			// ready drops on an accepted byte opcode, rises on load or refusal
			if (go_byte | arb_lost | (wr_op & (wr_abort | ~opcode_select[2] & ~opcode_select[1])))
				tx_ready_flag <= 1'b1;
			else if (wr_op | ((state_reg == S_WAIT) & eod_seen & pend_reg))
				tx_ready_flag <= ((state_reg == S_WAIT) & eod_seen & ~wr_op);
			if ((wr_op & wr_abort) | ((state_reg == S_WAIT) & eod_seen & pend_reg & ~resp_ok))
				request_aborted_flag <= 1'b1;
			else if (wr_en & (paddr == `VTX_OFS_STATUS) & pwdata[`VTX_ST_ABORT])
				request_aborted_flag <= 1'b0;
			if ((wr_op & wr_under) | (byte_end & non_fin & ~chain_ok & ~in_crc_reg))
				tx_underflow_flag <= 1'b1;
			else if (wr_en & (paddr == `VTX_OFS_STATUS) & pwdata[`VTX_ST_UNDER])
				tx_underflow_flag <= 1'b0;
		end
	end

	// read data is captured in the setup cycle, so the access phase needs no wait
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (rd_set)
		begin
			case (paddr)
				`VTX_OFS_OPCODE: prdata <= {24'h000000, opcode_reg};
				`VTX_OFS_TXBYTE: prdata <= {24'h000000, tx_byte_holding};
				`VTX_OFS_PADDR:  prdata <= {24'h000000, phys_addr_reg};
				`VTX_OFS_CTRL:   prdata <= {31'h00000000, frame_limit_off};
				`VTX_OFS_STATUS: prdata <= {27'h0000000, busy, locked_reg,
				                  tx_underflow_flag, request_aborted_flag, tx_ready_flag};
				default:         prdata <= 32'h00000000;
			endcase
		end
	end

	// ******************************************
	// transmit sequencer
	// ******************************************
	// break has top priority, then lost arbitration, then the state walk
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg          <= S_IDLE;
			locked_reg         <= 1'b0;
			pend_reg           <= 1'b0;
			pend_op_reg        <= `VTX_OP_CANCEL;
			pend_len_reg       <= 4'h0;
			op_reg             <= `VTX_OP_CANCEL;
			crc_after_reg      <= 1'b0;
			bad_crc_reg        <= 1'b0;
			in_crc_reg         <= 1'b0;
			shift_reg          <= 8'h00;
			bit_cnt_reg        <= 3'h0;
			timer_reg          <= 14'h0000;
			level_reg          <= 1'b0;
			crc_reg            <= `VTX_RST_CRC;
			encoded_bus_output <= 1'b0;
		end
		else if (wr_op & (opcode_select == `VTX_OP_BREAK))
		begin
			// break overrides everything in flight and drops the queue
			state_reg          <= S_BRK;
			timer_reg          <= BRK_CYC;
			encoded_bus_output <= 1'b1;
			pend_reg           <= 1'b0;
		end
		else if (arb_lost & busy)
		begin
			// go passive and stay out until the frame's end-of-data
			state_reg          <= S_IDLE;
			locked_reg         <= 1'b1;
			pend_reg           <= 1'b0;
			encoded_bus_output <= 1'b0;
		end
		else
		begin
			if (eod_seen)
				locked_reg <= 1'b0;
			// queue: a new opcode replaces the old, cancel just empties it
			if (wr_op & (state_reg != S_BRK))
			begin
				pend_reg     <= opcode_select[2] | opcode_select[1];
				pend_op_reg  <= opcode_select;
				pend_len_reg <= new_resp ? msg_length_count : 4'h0;
				if (wr_abort | (opcode_select == `VTX_OP_CANCEL))
					pend_reg <= 1'b0;
				if (wr_under)
					bad_crc_reg <= busy;
			end
			else if (go_byte)
				pend_reg <= 1'b0;
			if (go_byte)
			begin
				// load shifter and start the first bit
				shift_reg          <= byte_src;
				op_reg             <= pend_op_reg;
				crc_after_reg      <= pend_op_reg[0] & pend_op_reg[1];
				in_crc_reg         <= 1'b0;
				bit_cnt_reg        <= 3'h7;
				timer_reg          <= (byte_src[7] ^ first_lvl) ? LONG_CYC : SHORT_CYC;
				encoded_bus_output <= first_lvl;
				level_reg          <= first_lvl;
				state_reg          <= S_BIT;
				if (byte_end)
					crc_reg <= crc_upd;
			end
			else
			begin
				case (state_reg)
					S_IDLE:
					begin
						crc_reg   <= `VTX_RST_CRC;
						level_reg <= 1'b0;
						encoded_bus_output <= 1'b0;
						if (pend_reg & pend_msg & ~locked_reg & bus_idle)
						begin
							state_reg          <= S_SOF;
							timer_reg          <= SOF_CYC;
							encoded_bus_output <= 1'b1;
						end
						else if (pend_reg & pend_op_reg[2])
							state_reg <= S_WAIT;
					end
					S_SOF:
						if (tdone)
							state_reg <= S_IDLE; // queue emptied meanwhile
						else
							timer_reg <= timer_reg - 14'h0001;
					S_WAIT:
					begin
						// bus is passive before a response, so it opens active
						crc_reg   <= `VTX_RST_CRC;
						level_reg <= 1'b1;
						if (~pend_reg | pend_msg | eod_seen)
							state_reg <= S_IDLE;
						// a refused response must not linger into the next frame
						if (eod_seen & ~wr_op)
							pend_reg <= 1'b0;
					end
					S_BIT:
					begin
						if (~tdone)
							timer_reg <= timer_reg - 14'h0001;
						else
						begin
							crc_reg   <= crc_upd;
							level_reg <= ~level_reg;
							if (~last_bit)
							begin
								shift_reg          <= {shift_reg[6:0], 1'b0};
								bit_cnt_reg        <= bit_cnt_reg - 3'h1;
								timer_reg          <= dur_next;
								encoded_bus_output <= ~level_reg;
							end
							else if (~in_crc_reg & (crc_after_reg | bad_crc_reg | non_fin))
							begin
								// good crc goes out inverted; a damaged frame gets the raw value
								shift_reg     <= (crc_after_reg & ~bad_crc_reg & ~non_fin) ?
								                 ~crc_upd : crc_upd;
								in_crc_reg    <= 1'b1;
								crc_after_reg <= 1'b0;
								bad_crc_reg   <= 1'b0;
								bit_cnt_reg   <= 3'h7;
								timer_reg     <= ((crc_upd[7] ^ ~(crc_after_reg &
								                 ~bad_crc_reg & ~non_fin)) ^ level_reg) ?
								                 LONG_CYC : SHORT_CYC;
								encoded_bus_output <= ~level_reg;
							end
							else
							begin
								// passive end-of-data after the last byte
								state_reg          <= S_EOD;
								timer_reg          <= EOD_CYC;
								encoded_bus_output <= 1'b0;
								in_crc_reg         <= 1'b0;
							end
						end
					end
					S_EOD:
						if (tdone)
							state_reg <= S_IDLE;
						else
							timer_reg <= timer_reg - 14'h0001;
					S_BRK:
						if (tdone)
						begin
							state_reg          <= S_IDLE;
							encoded_bus_output <= 1'b0;
						end
						else
							timer_reg <= timer_reg - 14'h0001;
					default:
						state_reg <= S_IDLE;
				endcase
			end
		end
	end

endmodule // vtx_opseq
`default_nettype wire

// ===== tb/vtx_opseq_chk.sv
// port-level checks on the transmit opcode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "vtx_defines.vh"
// ************
// port checker
// ************
module vtx_opseq_chk (
	// clock, reset and apb
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	// receiver status and link
	input wire        bus_idle,
	input wire        eod_seen,
	input wire        crc_ok,
	input wire        encoded_bus_output
);
	wire acc = psel & penable;
	wire wtx = acc & pwrite & (paddr == `VTX_OFS_OPCODE);
	wire act = encoded_bus_output;
	wire rds = acc & !pwrite & (paddr == `VTX_OFS_STATUS);
	reg  lim_off;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow of the length limit switch, needed to judge length codes
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			lim_off <= 1'b0;
		else if (acc & pwrite & (paddr == `VTX_OFS_CTRL))
			lim_off <= pwdata[0];
	a_break_start: assert property (wtx && pwdata[2:0] == `VTX_OP_BREAK |-> ##[1:3] act[*8])
		else $error("break not driven at once");
	a_idle_sof: assert property (wtx && pwdata[2:1] == 2'b01 && bus_idle && !act |-> ##[1:4] act[*8])
		else $error("no start of frame on idle bus");
	a_ready_clears: assert property (wtx && pwdata[2:1] == 2'b01 && bus_idle ##[2:3] rds |-> !prdata[0])
		else $error("ready still set after opcode write");
	a_opreg_reserved: assert property (acc && !pwrite && paddr == `VTX_OFS_OPCODE |-> prdata[31:8] == 24'h0 && !prdata[3])
		else $error("opcode register reads reserved bits");
	a_resp_waits: assert property ((wtx && pwdata[2] && !act) ##1 (!eod_seen && !wtx)[*3] |-> !act)
		else $error("response sent before end of data");
	a_bad_length: assert property (wtx && pwdata[2] && pwdata[7:4] > 4'hb && !lim_off && !act |-> ##1 !act[*8])
		else $error("response sent with invalid length count");
	a_crc_gate: assert property (eod_seen && !crc_ok && !act |-> ##1 !act[*6])
		else $error("response sent after bad checksum");
	a_cancel_quiet: assert property (wtx && pwdata[2:0] == `VTX_OP_CANCEL && !act |-> ##1 !act[*4])
		else $error("cancel let a transmit start");
	c_break: cover property (wtx && pwdata[2:0] == `VTX_OP_BREAK);
	c_response: cover property (eod_seen && crc_ok ##[1:4] act);
	c_aborted: cover property (rds && prdata[1]);
endmodule // vtx_opseq_chk
bind vtx_opseq vtx_opseq_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .bus_idle, .eod_seen, .crc_ok, .encoded_bus_output);
`default_nettype wire

// ===== tb/vtx_bus_peer.sv
// behavioural model of the other bus nodes and the receive side
`timescale 1ns/1ps
`default_nettype none
// **********
// bus peer
// **********
module vtx_bus_peer (
	// link side
	input  wire        pclk,
	input  wire        presetn,
	input  wire        encoded_bus_output,
	// receiver status toward the sequencer
	output logic       bus_idle,
	output logic       eod_seen,
	output logic       arb_lost,
	output logic [3:0] rx_byte_count,
	output logic       rx_in_response,
	output logic       crc_ok,
	output logic       frame_sync_error,
	output logic       bit_decode_error,
	output logic       received_break_flag
);
	logic       in_frame;
	logic [4:0] quiet;
	initial
	begin
		{in_frame, eod_seen, arb_lost, rx_in_response, crc_ok} = 5'h0;
		{frame_sync_error, bit_decode_error, received_break_flag} = 3'h0;
		rx_byte_count = 4'h0;
	end
	// idle needs a passive stretch longer than any symbol, so bit gaps never look idle
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			quiet <= 5'h00;
		else if (encoded_bus_output)
			quiet <= 5'h00;
		else if (quiet != 5'h1f)
			quiet <= quiet + 5'h01;
	assign bus_idle = !in_frame && quiet == 5'h1f;
	// another node sends a frame body of n bytes
	task automatic frame(input logic [3:0] n, input logic good);
		@(posedge pclk);
		in_frame <= 1'b1;
		rx_byte_count <= n;
		crc_ok <= good;
	endtask
	// end-of-data symbol seen after the body
	task automatic eod();
		@(posedge pclk);
		eod_seen <= 1'b1;
		@(posedge pclk);
		eod_seen <= 1'b0;
	endtask
	task automatic done();
		@(posedge pclk);
		in_frame <= 1'b0;
		rx_byte_count <= 4'h0;
	endtask
	// another node wins arbitration for one cycle
	task automatic lose();
		@(posedge pclk);
		arb_lost <= 1'b1;
		@(posedge pclk);
		arb_lost <= 1'b0;
	endtask
	// receiver is inside the response portion of a frame
	task automatic respond(input logic v);
		@(posedge pclk);
		rx_in_response <= v;
	endtask
endmodule // vtx_bus_peer
`default_nettype wire

// ===== tb/tb_vtx_opseq.sv
// self-checking bench for the transmit opcode sequencer
`timescale 1ns/1ps
`default_nettype none
`include "vtx_defines.vh"
// **********
// bench top
// **********
module tb_vtx_opseq;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire         pready, pslverr, bus_idle, eod_seen, arb_lost, rx_in_response, crc_ok;
	wire         frame_sync_error, bit_decode_error, received_break_flag, encoded_bus_output;
	wire [31:0]  prdata;
	wire [3:0]   rx_byte_count;
	int          fails = 0;
	int          n_tests = 0;
	int          rl[$];
	logic        rv[$];
	int          run = 0;
	logic        lvl = 1'b0;
	logic [31:0] rd;
	logic        err;
	// {limit off, length code, bytes received, checksum good, response expected}
	logic [10:0] cs [8] = '{{1'b0, 4'd3, 4'd3, 2'b11}, {1'b0, 4'd5, 4'd3, 2'b10},
		{1'b0, 4'd12, 4'd12, 2'b10}, {1'b0, 4'd11, 4'd11, 2'b11}, {1'b1, 4'd12, 4'd12, 2'b11},
		{1'b0, 4'd0, 4'd7, 2'b11}, {1'b0, 4'd0, 4'd7, 2'b00}, {1'b0, 4'd0, 4'd12, 2'b10}};

	always #12.5 pclk = ~pclk;

	// short symbol times keep the run brief
	vtx_opseq #(.SHORT_CYC(14'd4), .LONG_CYC(14'd8), .SOF_CYC(14'd10), .EOD_CYC(14'd10),
		.BRK_CYC(14'd12)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .pslverr, .prdata, .bus_idle, .eod_seen, .arb_lost, .rx_byte_count,
		.rx_in_response, .crc_ok, .frame_sync_error, .bit_decode_error, .received_break_flag,
		.encoded_bus_output);
	vtx_bus_peer peer_u (.pclk, .presetn, .encoded_bus_output, .bus_idle, .eod_seen, .arb_lost,
		.rx_byte_count, .rx_in_response, .crc_ok, .frame_sync_error, .bit_decode_error,
		.received_break_flag);

	// log each constant stretch of the bus output; sampled away from the launching edge
	always @(negedge pclk)
	begin
		if (encoded_bus_output !== lvl)
		begin
			rl.push_back(run);
			rv.push_back(lvl);
			run = 1;
			lvl = encoded_bus_output;
		end
		else
			run = run + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen at an access edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// a wait that never ends is left to the bench watchdog
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	// a long symbol carries the inverse of its level
	function automatic logic [15:0] decode(input int f, input int n);
		logic [15:0] v;
		v = 16'h0;
		for (int i = 0; i < n; i++)
			v = {v[14:0], (rl[f + i] > 6) ? ~rv[f + i] : rv[f + i]};
		return v;
	endfunction

	function automatic int first_high();
		foreach (rl[i])
			if (rv[i] === 1'b1)
				return i;
		return -1;
	endfunction

	function automatic logic [7:0] crc8(input logic [7:0] b);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 7; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? `VTX_CRC_POLY : 8'h00);
		return ~c;
	endfunction

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// whole run needs about 1500 cycles
	initial
	begin
		#(25 * 20000);
		fails++;
		summarize();
	end

	initial
	begin
		int h;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`VTX_OFS_OPCODE, 32'h0);
		rdc(`VTX_OFS_STATUS, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		check({30'h0, err, pready}, 32'h3);
		check(rd, 32'h0);
		apb(1'b1, `VTX_OFS_OPCODE, 32'hff);
		rdc(`VTX_OFS_OPCODE, 32'hf7);
		rdc(`VTX_OFS_STATUS, 32'h3);
		apb(1'b1, `VTX_OFS_STATUS, 32'h6);
		$display("test registers done");
		apb(1'b1, `VTX_OFS_OPCODE, 32'h1);
		apb(1'b1, `VTX_OFS_OPCODE, 32'h0);
		check({31'h0, encoded_bus_output}, 32'h1);
		repeat (20) @(posedge pclk);
		check({31'h0, encoded_bus_output}, 32'h0);
		$display("test break done");
		for (int k = 0; k < 200 && bus_idle !== 1'b1; k++)
			@(posedge pclk);
		rl.delete();
		rv.delete();
		apb(1'b1, `VTX_OFS_TXBYTE, 32'ha5);
		apb(1'b1, `VTX_OFS_OPCODE, 32'hf3);
		apb(1'b0, `VTX_OFS_STATUS, 32'h0);
		check(rd & 32'h1, 32'h0);
		repeat (250) @(posedge pclk);
		h = first_high();
		check(32'(rl[h]), 32'd10);
		check(decode(h + 1, 16), {8'ha5, crc8(8'ha5)});
		rdc(`VTX_OFS_STATUS, 32'h1);
		$display("test message done");
		foreach (cs[i])
		begin
			apb(1'b1, `VTX_OFS_CTRL, {31'h0, cs[i][10]});
			apb(1'b1, `VTX_OFS_PADDR, 32'h3c);
			peer_u.frame(cs[i][5:2], cs[i][1]);
			rl.delete();
			rv.delete();
			apb(1'b1, `VTX_OFS_OPCODE, {24'h0, cs[i][9:6], 4'h4});
			repeat (2) @(posedge pclk);
			peer_u.eod();
			repeat (100) @(posedge pclk);
			check({31'h0, first_high() >= 0}, {31'h0, cs[i][0]});
			if (cs[i][0])
				check(decode(first_high(), 7), 32'h1e);
			peer_u.done();
			apb(1'b1, `VTX_OFS_STATUS, 32'h6);
		end
		apb(1'b1, `VTX_OFS_CTRL, 32'h0);
		$display("test responses done");
		peer_u.frame(4'd3, 1'b1);
		rl.delete();
		rv.delete();
		apb(1'b1, `VTX_OFS_OPCODE, 32'h34);
		apb(1'b1, `VTX_OFS_OPCODE, 32'h0);
		peer_u.eod();
		repeat (100) @(posedge pclk);
		check({31'h0, first_high() >= 0}, 32'h0);
		rdc(`VTX_OFS_STATUS, 32'h1);
		peer_u.done();
		$display("test cancel done");
		// lost arbitration silences the sender until the frame's end of data
		for (int k = 0; k < 200 && bus_idle !== 1'b1; k++)
			@(posedge pclk);
		apb(1'b1, `VTX_OFS_TXBYTE, 32'h5a);
		apb(1'b1, `VTX_OFS_OPCODE, 32'h2);
		repeat (12) @(posedge pclk);
		peer_u.lose();
		repeat (3) @(posedge pclk);
		check({31'h0, encoded_bus_output}, 32'h0);
		rdc(`VTX_OFS_STATUS, 32'h9);
		peer_u.eod();
		rdc(`VTX_OFS_STATUS, 32'h1);
		$display("test arbitration done");
		// a response asked for while one is being received is refused
		peer_u.frame(4'd3, 1'b1);
		peer_u.respond(1'b1);
		apb(1'b1, `VTX_OFS_OPCODE, 32'h34);
		rdc(`VTX_OFS_STATUS, 32'h3);
		peer_u.respond(1'b0);
		peer_u.done();
		$display("test refusal done");
		summarize();
	end
endmodule // tb_vtx_opseq
`default_nettype wire
